/* hw/ccm_top.sv */
// Design: serial-programmed output code register bank with output multiplexer
// Summary of operation
// - After reset the output port follows the parallel inputs.
// - Serial slave works at standard and fast bit rates.
// - Override low forces outputs to zero, refined by the truth table.
// - Write-protect high discards serial writes; stored codes stay unchanged.
// - Path-select low passes the selected code; high passes the inputs.
// - Unmuxed latch follows the chosen code while path-select low, holds while high or with no code chosen.
// - Held unmuxed value is the one present when path-select rose.
// - Source selection changes only at a stop condition.
// - Two read/write code registers at index 0 and 1.
// - Read-only snapshot register at index 2 holds the input port.
// - Top two bits choose source: 00 code A, 01 code B, 10 inputs.
// - Bits 5 and 3..0 form the five-bit output code.
// - Bit 4 of a code register feeds the unmuxed output.
// - Snapshot reads zero in bits 7..5, input levels in bits 4..0.
// - Snapshot captures the inputs at the first serial clock after start.
// - Override and path-select high: inputs on port, unmuxed from last code.
// - Answer only the address chosen by the pick pin; ignore general call.
// - Write byte: top two bits pick the register, low six the code.
// - Reads return code A, code B, snapshot in order; stop ends early.
// - Written codes reach the outputs only after the ten millisecond update.
`timescale 1ns/1ps
module ccm_top
    import ccm_pkg::*;
#(
    parameter int NV_WRITE_CYCLES_P = NV_WRITE_CYCLES
) (
    // System clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // Serial link
    input  wire logic       scl_clk_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    // Control pins
    input  wire logic       force_zero_n_i,
    input  wire logic       path_select_i,
    input  wire logic       write_protect_i,
    input  wire logic       slave_address_pick_i,
    // Parallel ports
    input  wire logic [4:0] i_port_i,
    output logic      [4:0] y_o,
    output logic            unmuxed_bit_o
);

    // ==========================================================
    // Link domain
    logic [7:0] rx_shift;
    logic       rise_tgl;

    // Bits are sampled on the link's own rising edge, where data is stable
    always_ff @(posedge scl_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_shift <= 8'h00;
            rise_tgl <= 1'b0;
        end else begin
            rx_shift <= {rx_shift[6:0], sda_i};
            rise_tgl <= ~rise_tgl;
        end
    end

    // ==========================================================
    // Synchronisers into the system domain
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic [2:0]  edge_d;

    // First stage is read only by the second
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= 12'h000;
            sync2 <= 12'h000;
        end else begin
            sync1 <= {rise_tgl, scl_clk_i, sda_i, i_port_i, force_zero_n_i,
                      path_select_i, write_protect_i, slave_address_pick_i};
            sync2 <= sync1;
        end
    end

    wire       tgl_s  = sync2[11];
    wire       scl_s  = sync2[10];
    wire       sda_s  = sync2[9];
    wire [4:0] port_s = sync2[8:4];
    wire       fz_n_s = sync2[3];
    wire       psel_s = sync2[2];
    wire       wp_s   = sync2[1];
    wire       pick_s = sync2[0];

    // Delayed copies for edge detection
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            edge_d <= 3'h0;
        end else begin
            edge_d <= {tgl_s, scl_s, sda_s};
        end
    end

    // Bus events; the link word is stable for a whole bit after the toggle
    wire rise_evt  = tgl_s ^ edge_d[2];
    wire fall_evt  = edge_d[1] & ~scl_s;
    wire start_evt = scl_s & edge_d[1] & edge_d[0] & ~sda_s;
    wire stop_evt  = scl_s & edge_d[1] & ~edge_d[0] & sda_s;

    // ==========================================================
    // Serial protocol state
    ccm_phase_type phase;
    logic [3:0]    bit_cnt;
    logic          read_req;
    logic          first_clk;
    logic [1:0]    rd_idx;
    logic [7:0]    tx_byte;
    logic [4:0]    snapshot;
    ccm_code_type  pend_a;
    ccm_code_type  pend_b;
    ccm_code_type  nv_a;
    ccm_code_type  nv_b;
    logic [1:0]    src_pend;
    logic [1:0]    src_live;
    logic [31:0]   nv_timer;
    logic          sda_oe;
    logic [4:0]    y_q;
    logic          unmuxed_q;

    // Decodes on the incoming byte
    wire [6:0] own_addr  = pick_s ? ADDR_PICK_HI : ADDR_PICK_LO;
    wire       addr_hit  = (rx_shift[7:1] == own_addr);
    wire       byte_done = rise_evt && (bit_cnt == 4'h7);
    wire       ack_rise  = rise_evt && (bit_cnt == BIT_CNT_ACK);
    wire [1:0] wr_dest   = rx_shift[7:6];
    wire       wr_ok     = byte_done && (phase == PH_WRITE) && !wp_s;
    wire       wr_a      = wr_ok && (wr_dest == SRC_CODE_A);
    wire       wr_b      = wr_ok && (wr_dest == SRC_CODE_B);
    wire       wr_src    = wr_ok && (wr_dest != 2'h3);
    wire       nv_done   = (nv_timer == 32'd1);

    // Read data; select bits are shared, so both code registers show them
    wire [1:0] next_idx  = (rd_idx == IDX_SNAPSHOT) ? IDX_SNAPSHOT : rd_idx + 2'h1;
    wire [1:0] load_idx  = (phase == PH_ADDR) ? IDX_CODE_A : next_idx;
    wire [7:0] rd_word   = (load_idx == IDX_CODE_A) ? {src_pend, nv_a} :
                           (load_idx == IDX_CODE_B) ? {src_pend, nv_b} :
                           {3'h0, snapshot};

    // Pin drive for the next bit, changed only while the clock is low
    wire drive_ack = (bit_cnt == BIT_CNT_ACK) &&
                     ((phase == PH_ADDR) || (phase == PH_WRITE));
    wire drive_dat = (phase == PH_READ) && (bit_cnt < BIT_CNT_ACK) &&
                     !tx_byte[~bit_cnt[2:0]];
    wire next_oe   = drive_ack || drive_dat;

    // Bit counter and transfer phase
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase    <= PH_IDLE;
            bit_cnt  <= BIT_CNT_ZERO;
            read_req <= 1'b0;
        end else if (start_evt) begin
            phase   <= PH_ADDR;
            bit_cnt <= BIT_CNT_ZERO;
        end else if (stop_evt) begin
            phase <= PH_IDLE;
        end else if (ack_rise) begin
            bit_cnt <= BIT_CNT_ZERO;
            if (phase == PH_ADDR) begin
                phase <= read_req ? PH_READ : PH_WRITE;
            end else if ((phase == PH_READ) && rx_shift[0]) begin
                phase <= PH_IGNORE; // Master declined more data
            end
        end else if (rise_evt) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (byte_done && (phase == PH_ADDR)) begin
                read_req <= rx_shift[0];
                if (!addr_hit) begin
                    phase <= PH_IGNORE;
                end
            end
        end
    end

    // Read pointer and transmit byte
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_idx  <= IDX_CODE_A;
            tx_byte <= 8'h00;
        end else if (ack_rise && ((phase == PH_ADDR) || (phase == PH_READ))) begin
            rd_idx  <= load_idx;
            tx_byte <= rd_word;
        end
    end

    // Input snapshot on the first clock after a start
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            first_clk <= 1'b0;
            snapshot  <= PORT_RESET;
        end else if (start_evt) begin
            first_clk <= 1'b1;
        end else if (rise_evt && first_clk) begin
            first_clk <= 1'b0;
            snapshot  <= port_s;
        end
    end

    // Data line drive; released at start, stop and outside our transfers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_oe <= 1'b0;
        end else if (start_evt || stop_evt) begin
            sda_oe <= 1'b0;
        end else if (fall_evt) begin
            sda_oe <= next_oe;
        end
    end

    // ==========================================================
    // Code registers and the slow non-volatile update
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_a   <= CODE_RESET;
            pend_b   <= CODE_RESET;
            src_pend <= SRC_RESET;
        end else begin
            if (wr_a) begin
                pend_a <= rx_shift[5:0];
            end
            if (wr_b) begin
                pend_b <= rx_shift[5:0];
            end
            if (wr_src) begin
                src_pend <= wr_dest;
            end
        end
    end

    // A write restarts the update; the outputs see the data only at its end
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nv_timer <= 32'd0;
            nv_a     <= CODE_RESET;
            nv_b     <= CODE_RESET;
        end else if (wr_a || wr_b) begin
            nv_timer <= 32'(NV_WRITE_CYCLES_P);
        end else if (nv_timer != 32'd0) begin
            nv_timer <= nv_timer - 32'd1;
            if (nv_done) begin
                nv_a <= pend_a;
                nv_b <= pend_b;
            end
        end
    end

    // Mux path moves only at a stop, never inside a transfer
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            src_live <= SRC_RESET;
        end else if (stop_evt) begin
            src_live <= src_pend;
        end
    end

    // ==========================================================
    // Output multiplexer
    wire          all_zero  = !fz_n_s && !psel_s;
    wire          code_sel  = (src_live == SRC_CODE_A) || (src_live == SRC_CODE_B);
    wire          code_path = fz_n_s && !psel_s && code_sel;
    wire          bad_sel   = fz_n_s && !psel_s && (src_live == 2'h3);
    ccm_code_type sel_code;
    assign sel_code = (src_live == SRC_CODE_A) ? nv_a : nv_b;

    // Port follows inputs unless path-select is low with override low, a code chosen or select 11
    wire [4:0] next_y   = all_zero  ? PORT_RESET :
                          code_path ? {sel_code.d5, sel_code.d_lo} :
                          bad_sel   ? PORT_RESET : port_s;
    // Unmuxed bit holds unless forced low or driven by a code, so a rise keeps the old value
    wire       next_unmuxed = all_zero  ? 1'b0 :
                              code_path ? sel_code.unmuxed_bit : unmuxed_q;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            y_q       <= PORT_RESET;
            unmuxed_q <= 1'b0;
        end else begin
            y_q       <= next_y;
            unmuxed_q <= next_unmuxed;
        end
    end

    // Outputs straight from flops; the data pin only ever pulls low
    assign y_o           = y_q;
    assign unmuxed_bit_o = unmuxed_q;
    assign sda_oe_o      = sda_oe;
    assign sda_o         = 1'b0;

endmodule : ccm_top

/* pkg/ccm_pkg.sv */
// Package: constants and types for the configuration output mux controller
package ccm_pkg;

    // ==========================================================
    // Timing
    localparam int SYS_CLK_HZ      = 20_000_000;
    localparam int NV_WRITE_MS     = 10;
    localparam int NV_WRITE_CYCLES = NV_WRITE_MS * (SYS_CLK_HZ / 1000);

    // ==========================================================
    // Slave addresses, picked by the address-select pin
    localparam logic [6:0] ADDR_PICK_HI = 7'h4e;
    localparam logic [6:0] ADDR_PICK_LO = 7'h37;

    // ==========================================================
    // Register indices in read order
    localparam logic [1:0] IDX_CODE_A   = 2'h0;
    localparam logic [1:0] IDX_CODE_B   = 2'h1;
    localparam logic [1:0] IDX_SNAPSHOT = 2'h2;

    // ==========================================================
    // Source-select codes (top two bits of a code register)
    localparam logic [1:0] SRC_CODE_A = 2'h0;
    localparam logic [1:0] SRC_CODE_B = 2'h1;
    localparam logic [1:0] SRC_INPUTS = 2'h2;
    localparam logic [1:0] SRC_RESET  = SRC_INPUTS;

    // ==========================================================
    // Reset values and bit counts
    localparam logic [5:0] CODE_RESET   = 6'h00;
    localparam logic [4:0] PORT_RESET   = 5'h00;
    localparam logic [3:0] BIT_CNT_ACK  = 4'h8;
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;

    // ==========================================================
    // Stored code: data bit 5, unmuxed bit, data bits 3..0
    typedef struct packed {
        logic       d5;
        logic       unmuxed_bit;
        logic [3:0] d_lo;
    } ccm_code_type;

    // Serial transfer phase
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_WRITE,
        PH_READ,
        PH_IGNORE
    } ccm_phase_type;

endpackage : ccm_pkg

/* dv/ccm_checker.sv */
// Checker: pin-level timing relations of the mux controller
`timescale 1ns/1ps
module ccm_checker (
    // Watched pins
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire logic       scl_clk_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic       force_zero_n_i,
    input wire logic       path_select_i,
    input wire logic [4:0] i_port_i,
    input wire logic [4:0] y_o,
    input wire logic       unmuxed_bit_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // ==========
    // Six quiet samples cover the 2FF stage plus the output flop
    sequence quiet_pins;
        ($stable(i_port_i) && $stable(force_zero_n_i) && $stable(path_select_i))[*6];
    endsequence
    AST_RESET_ROUTE: assert property ($fell(rst_i) ##0 quiet_pins |-> y_o == i_port_i)
        else $error("inputs not routed after reset");
    AST_FORCE_ZERO: assert property ((!force_zero_n_i && !path_select_i) ##0 quiet_pins
        |-> y_o == 5'h00 && !unmuxed_bit_o) else $error("outputs not forced low");
    AST_PATH_INPUTS: assert property (path_select_i ##0 quiet_pins |-> y_o == i_port_i)
        else $error("port does not follow inputs");
    AST_LATCH_HOLD: assert property (path_select_i[*6] |-> $stable(unmuxed_bit_o))
        else $error("unmuxed bit moved while held");
    AST_LATCH_VALUE: assert property ($rose(path_select_i) ##1 path_select_i[*8]
        |-> unmuxed_bit_o == $past(unmuxed_bit_o, 8)) else $error("wrong held unmuxed value");
    // Data may only move while the serial clock is low
    AST_OE_SCL_LOW: assert property ($changed(sda_oe_o) |-> !scl_clk_i)
        else $error("data moved with clock high");
    AST_IDLE_RELEASE: assert property (scl_clk_i[*8] |-> !sda_oe_o)
        else $error("data held low while idle");
    AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
endmodule : ccm_checker

bind ccm_top ccm_checker u_ccm_checker (.sys_clk_i, .rst_i, .scl_clk_i, .sda_o, .sda_oe_o,
    .force_zero_n_i, .path_select_i, .i_port_i, .y_o, .unmuxed_bit_o);

/* dv/ccm_iic_master.sv */
// Serial master model: drives the link clock and pulls the data line low
`timescale 1ns/1ps
module ccm_iic_master (
    // Link wires
    output logic      scl_o,
    output logic      sda_low_o,
    input  wire logic sda_i
);
    // Phases are whole 64 ns link ticks; low phase stays above 200 ns
    localparam time Q = 128ns;
    localparam time T = 320ns;
    // ==========
    // Clock stands high and data released between frames
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // Start (s=0) or stop (s=1): data moves while clock high
    task automatic cond(input logic s);
        #Q sda_low_o = s;
        #T scl_o = 1'b1;
        #T sda_low_o = !s;
        #T scl_o = s;
    endtask : cond
    // One bit; data changes a while after the fall to stay clear of false starts
    task automatic bit_x(input logic b, output logic r);
        #Q sda_low_o = !b;
        #T scl_o = 1'b1;
        #T r = sda_i;
        scl_o = 1'b0;
    endtask : bit_x
    // Byte MSB first, then the ninth bit; released ninth bit returns the ack
    task automatic xfer(input logic [7:0] d, input logic a9, output logic [7:0] q,
                        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(a9, r);
        ack = !r;
    endtask : xfer
    // Start plus address byte with direction flag
    task automatic begin_frame(input logic [6:0] a, input logic rd, output logic ack);
        logic [7:0] q;
        cond(1'b0);
        xfer({a, rd}, 1'b1, q, ack);
    endtask : begin_frame
endmodule : ccm_iic_master

/* dv/ccm_top_test.sv */
// Testbench: random and corner checks of the mux controller
`timescale 1ns/1ps
module ccm_top_test;
    import ccm_pkg::*;
    localparam int NVW = 20; // Short update time keeps the run brief
    // ==========
    // Pins, link wires and expected state
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         fzn = 1'b1;
    logic         psel = 1'b0;
    logic         wp = 1'b0;
    logic         pick = 1'b1;
    logic [4:0]   ip = 5'h00;
    logic [4:0]   y;
    logic         unm;
    logic         sda_oe;
    wire          scl, sda_low, sda_w;
    logic [1:0]   sel = SRC_RESET;
    ccm_code_type code [2] = '{default: CODE_RESET};
    logic         m_unm = 1'b0;
    int           mismatches = 0;
    int           cmp_count = 0;
    // Clock, pulled-up data line, design and master
    always #25 clk = !clk;
    assign sda_w = !(sda_oe || sda_low);
    ccm_top #(.NV_WRITE_CYCLES_P(NVW)) dut (.sys_clk_i(clk), .rst_i(rst), .scl_clk_i(scl),
        .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .force_zero_n_i(fzn),
        .path_select_i(psel), .write_protect_i(wp), .slave_address_pick_i(pick),
        .i_port_i(ip), .y_o(y), .unmuxed_bit_o(unm));
    ccm_iic_master master (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));
    // ==========
    // Expectations from the truth table
    function automatic logic [4:0] exp_y();
        if (psel || (fzn && sel == SRC_INPUTS)) return ip;
        if (!fzn) return 5'h00;
        return {code[sel[0]].d5, code[sel[0]].d_lo};
    endfunction : exp_y
    function automatic logic exp_unm();
        if (!fzn && !psel) return 1'b0;
        if (psel || sel == SRC_INPUTS) return m_unm;
        return code[sel[0]].unmuxed_bit;
    endfunction : exp_unm
    // Compare and verdict
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Let pins pass the synchronisers, then compare both outputs
    task automatic check_mux();
        repeat (8) @(negedge clk);
        m_unm = exp_unm();
        chk("y", {3'h0, exp_y()}, {3'h0, y});
        chk("unmuxed", {7'h0, m_unm}, {7'h0, unm});
    endtask : check_mux
    task automatic pins(input logic f, input logic p, input logic w);
        @(negedge clk);
        fzn = f;
        psel = p;
        wp = w;
    endtask : pins
    // One-byte write; the mux keeps its source until the stop
    task automatic wr(input logic [7:0] d);
        logic [7:0] q;
        logic a1, a2;
        master.begin_frame(pick ? ADDR_PICK_HI : ADDR_PICK_LO, 1'b0, a1);
        master.xfer(d, 1'b1, q, a2);
        chk("acks", 8'h03, {6'h0, a1, a2});
        if (!wp && d[7:6] != SRC_INPUTS) code[d[6]] = d[5:0];
        repeat (NVW) @(negedge clk);
        check_mux();
        master.cond(1'b1);
        if (!wp) sel = d[7:6];
        check_mux();
        $display("test write done");
    endtask : wr
    // Full read; inputs move after the start to prove the early capture
    task automatic rd();
        logic [7:0] q;
        logic [4:0] ip0;
        logic a;
        ip0 = ip;
        master.begin_frame(pick ? ADDR_PICK_HI : ADDR_PICK_LO, 1'b1, a);
        @(negedge clk);
        ip = 5'($urandom);
        for (int k = 0; k < 3; k++) begin
            master.xfer(8'hff, k == 2, q, a);
            chk("read", k == 2 ? {3'h0, ip0} : {sel, code[k]}, q);
        end
        master.cond(1'b1);
        $display("test read done");
    endtask : rd
    task automatic mux_rand(input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge clk);
            {fzn, psel, ip} = 7'($urandom);
            check_mux();
        end
        pins(1'b1, 1'b0, 1'b0);
        $display("test mux done");
    endtask : mux_rand
    // Each pick level against both addresses and the general call
    task automatic addr_scan();
        logic [6:0] al [3] = '{ADDR_PICK_HI, ADDR_PICK_LO, 7'h00};
        logic [7:0] q;
        logic a, n;
        for (int p = 0; p < 2; p++) begin
            foreach (al[j]) begin
                pick = p[0];
                repeat (8) @(negedge clk);
                master.begin_frame(al[j], 1'b1, a);
                chk("addr ack", {7'h0, al[j] == (p[0] ? ADDR_PICK_HI : ADDR_PICK_LO)}, {7'h0, a});
                if (a) master.xfer(8'hff, 1'b1, q, n);
                master.cond(1'b1);
            end
        end
        $display("test address done");
    endtask : addr_scan
    // Watchdog: a stuck run counts as a mismatch
    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        void'($urandom(32'h62ed));
        ip = 5'($urandom);
        repeat (16) @(negedge clk);
        rst = 1'b0;
        check_mux();
        rd();
        wr({SRC_CODE_A, 6'($urandom)});
        wr({SRC_CODE_B, 6'($urandom)});
        pins(1'b1, 1'b0, 1'b1);
        wr({SRC_CODE_B, 6'($urandom)});
        pins(1'b1, 1'b0, 1'b0);
        rd();
        mux_rand(40);
        wr({SRC_INPUTS, 6'h3f});
        mux_rand(20);
        addr_scan();
        report_and_stop();
    end
endmodule : ccm_top_test
